// file: verilog/hpc_convert_top.sv
// Purpose: Single-to-half conversion with exception flags behind Avalon-MM
// Assumes: One clock, software drives operands through registers
// Notes:   A write to the source register converts in the same bus cycle
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns

module hpc_convert_top
  import hpc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [6:0]        ctrlQ,   ctrlD;
  logic [NFLAGS-1:0] statusQ, statusD;
  logic [NFLAGS-1:0] irqEnQ,  irqEnD;
  logic [7:0]        immQ,    immD;
  logic [15:0]       resultQ, resultD;
  logic              resFaultQ, resFaultD;
  logic [2:0]        xstateQ, xstateD;
  logic              ackQ,    ackD;
  logic [31:0]       rdataQ,  rdataD;

  // ----------------------------------------
  // Conversion datapath
  // ----------------------------------------
  logic              cvtGo;
  logic              sgn, isNan, isSnan, isInf, isZero, srcDen;
  logic [7:0]        ex;
  logic [22:0]       fr;
  logic signed [9:0] heS, shBig;
  logic [5:0]        sh;
  logic [48:0]       wide;
  logic [10:0]       kept;
  logic              gBit, sBit, inc, tiny, ovfDet, inexDet, rule5Hit, preFault;
  logic [15:0]       rndHalf;
  hpc_rnd_t          rmode;
  logic [NMASKS-1:0] msk;
  logic [NFLAGS-1:0] newFlags;
  logic              fault, deliver;
  logic [15:0]       cvtRes;

  // Bus handshake: one wait cycle, then the request is taken
  assign avs_waitrequest = (avs_read | avs_write) & ~ackQ;
  assign cvtGo = avs_write & ackQ & (avs_address == OFS_SRC);
  assign msk   = ctrlQ[NMASKS-1:0];

  // Rounding field from imm or control word; imm[7:3] never looked at
  function automatic hpc_rnd_t imm_rnd(input logic [7:0] imm, input logic [1:0] rf);
    imm_rnd = imm[IMM_RND_SELECT] ? hpc_rnd_t'(rf) : hpc_rnd_t'(imm[1:0]);
  endfunction

  // Operand classification and shift for rounding
  always_comb begin
    sgn    = avs_writedata[31];
    ex     = avs_writedata[30:23];
    fr     = avs_writedata[22:0];
    isNan  = (ex == EXP_SPECIAL) && (fr != 23'h0);
    isSnan = isNan && !fr[22];
    isInf  = (ex == EXP_SPECIAL) && (fr == 23'h0);
    isZero = (ex == 8'h00) && (fr == 23'h0);
    srcDen = (ex == 8'h00) && (fr != 23'h0);
    heS    = $signed({2'b00, ex}) - 10'(EXP_REBIAS);
    shBig  = 10'(SHIFT_NORM + 1) - heS;
    if (heS >= 10'sd1) begin
      sh = 6'(SHIFT_NORM);
    end else if (shBig > 10'(SHIFT_MAX)) begin
      sh = 6'(SHIFT_MAX);
    end else begin
      sh = shBig[5:0];
    end
    wide = {(ex != 8'h00), fr, 25'h0} >> sh;
    kept = wide[35:25];
    gBit = wide[24];
    sBit = |wide[23:0];
    rmode = imm_rnd(immQ, ctrlQ[CTRL_RND_LSB +: 2]);
    case (rmode)
      RND_NEAREST: inc = gBit & (sBit | kept[0]);
      RND_DOWN:    inc = sgn & (gBit | sBit);
      RND_UP:      inc = ~sgn & (gBit | sBit);
      RND_TRUNC:   inc = 1'b0;
      default:     inc = 1'b0;
    endcase
    // Carry out of the fraction bumps the exponent for free
    rndHalf = (heS >= 10'sd1) ? {1'b0, heS[4:0], kept[9:0]} : {6'h00, kept[9:0]};
    rndHalf = rndHalf + {15'h0, inc};
  end

  // Exception detection and result selection
  always_comb begin
    ovfDet   = !isNan && !isInf && ((heS >= 10'(HEXP_OVF)) || (rndHalf >= HALF_INF));
    tiny     = !isNan && !isInf && !isZero && (heS < 10'sd1);
    inexDet  = !isNan && !isInf && (gBit | sBit | ovfDet);
    // masked denormal meets unmasked precision or underflow
    rule5Hit = srcDen && msk[FLG_DEN] && (!msk[FLG_PREC] || !msk[FLG_UNF]);
    preFault = (isSnan && !msk[FLG_INV]) || (srcDen && !msk[FLG_DEN]);
    newFlags = '0;
    newFlags[FLG_INV] = isSnan;
    newFlags[FLG_DEN] = srcDen;
    if (!preFault) begin
      newFlags[FLG_OVF]  = ovfDet;
      newFlags[FLG_UNF]  = rule5Hit || (tiny && (!msk[FLG_UNF] || inexDet));
      newFlags[FLG_PREC] = rule5Hit || (inexDet && !(ovfDet && !msk[FLG_OVF])
                                              && !(tiny && !msk[FLG_UNF]));
    end
    fault = |(newFlags[NMASKS-1:0] & ~msk);
    newFlags[FLG_FAULT] = fault;
    deliver = !preFault && !rule5Hit && !(ovfDet && !msk[FLG_OVF])
              && !(tiny && !msk[FLG_UNF]);
    if (isNan) begin
      cvtRes = {sgn, 5'h1F, 1'b1, fr[21:13]};  // Quieted, low bits dropped
    end else if (isInf || ovfDet) begin
      cvtRes = {sgn, HALF_INF[14:0]};
    end else begin
      cvtRes = {sgn, rndHalf[14:0]};
    end
  end

  // ----------------------------------------
  // Register file next state
  // ----------------------------------------
  always_comb begin
    ctrlD     = ctrlQ;
    statusD   = statusQ;
    irqEnD    = irqEnQ;
    immD      = immQ;
    resultD   = resultQ;
    resFaultD = resFaultQ;
    xstateD   = xstateQ;
    ackD      = (avs_read | avs_write) & ~ackQ;
    rdataD    = rdataQ;
    // Read data is captured in the wait cycle so it stands at the take edge
    if (avs_read && !ackQ) begin
      case (avs_address)
        OFS_CTRL:    rdataD = {25'h0, ctrlQ};
        OFS_STATUS:  rdataD = {26'h0, statusQ};
        OFS_IRQ_EN:  rdataD = {26'h0, irqEnQ};
        OFS_IMM:     rdataD = {24'h0, immQ};
        OFS_RESULT:  rdataD = {15'h0, resFaultQ, resultQ};
        OFS_FEATURE: rdataD = FEATURE_WORD;
        OFS_XSTATE:  rdataD = {29'h0, xstateQ};
        default:     rdataD = 32'h0;
      endcase
    end
    if (avs_write && ackQ) begin
      case (avs_address)
        OFS_CTRL:   ctrlD   = avs_writedata[6:0];
        OFS_STATUS: statusD = statusQ & ~avs_writedata[NFLAGS-1:0];
        OFS_IRQ_EN: irqEnD  = avs_writedata[NFLAGS-1:0];
        OFS_IMM:    immD    = avs_writedata[7:0];
        OFS_XSTATE: xstateD = avs_writedata[2:0];
        default:    ;
      endcase
    end
    // flags accumulate; a set beats a clear
    if (cvtGo) begin
      statusD   = statusD | newFlags;
      resFaultD = fault;
      if (deliver) begin
        resultD = cvtRes;
      end
    end
  end

  // Registers only; reset loads constants
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrlQ     <= CTRL_RST;
      statusQ   <= '0;
      irqEnQ    <= '0;
      immQ      <= 8'h00;
      resultQ   <= 16'h0000;
      resFaultQ <= 1'b0;
      xstateQ   <= XSTATE_RST;
      ackQ      <= 1'b0;
      rdataQ    <= 32'h0;
    end else begin
      ctrlQ     <= ctrlD;
      statusQ   <= statusD;
      irqEnQ    <= irqEnD;
      immQ      <= immD;
      resultQ   <= resultD;
      resFaultQ <= resFaultD;
      xstateQ   <= xstateD;
      ackQ      <= ackD;
      rdataQ    <= rdataD;
    end
  end

  assign avs_readdata = rdataQ;
  assign irq          = |(statusQ & irqEnQ);  // Level, held while any enabled flag stands

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_ovf_flag_set: assert property (
    cvtGo && ovfDet && !preFault |=> statusQ[FLG_OVF]
  ) else $error("overflow did not raise its flag");

  chk_ovf_masked_inf: assert property (
    cvtGo && ovfDet && !isNan && msk[FLG_OVF] && !preFault && !rule5Hit
    |=> resultQ[14:0] == HALF_INF[14:0]
  ) else $error("masked overflow did not give infinity");

  chk_inexact_detect: assert property (
    cvtGo && !isNan && !isInf && (gBit || sBit) |-> inexDet
  ) else $error("lost bits not seen as inexact");

  chk_prec_masked: assert property (
    cvtGo && inexDet && msk[FLG_PREC] && !preFault && !(ovfDet && !msk[FLG_OVF])
    && !(tiny && !msk[FLG_UNF]) |=> statusQ[FLG_PREC] && resultQ == $past(cvtRes)
  ) else $error("masked inexact result or flag wrong");

  chk_prec_unmasked_ovf: assert property (
    cvtGo && ovfDet && !msk[FLG_PREC] && msk[FLG_OVF] && !preFault && !rule5Hit
    |=> statusQ[FLG_OVF] && statusQ[FLG_PREC] && resFaultQ
  ) else $error("unmasked precision with masked overflow wrong");

  chk_den_triple: assert property (
    cvtGo && srcDen && msk[FLG_DEN] && (!msk[FLG_PREC] || !msk[FLG_UNF])
    |=> statusQ[FLG_DEN] && statusQ[FLG_UNF] && statusQ[FLG_PREC] && resFaultQ
  ) else $error("denormal source did not raise all three flags");

  chk_feature_bits: assert property (
    avs_read && !avs_waitrequest && avs_address == OFS_FEATURE |-> avs_readdata[29:28] == 2'b11
  ) else $error("feature word lacks conversion bits");

  chk_rnd_select: assert property (
    cvtGo |-> rmode == (immQ[IMM_RND_SELECT] ? ctrlQ[6:5] : immQ[1:0])
  ) else $error("rounding source chosen wrongly");

  chk_unf_threshold: assert property (
    cvtGo && avs_writedata[30:0] < 31'h38800000 && avs_writedata[30:0] != 31'h0
    && !msk[FLG_UNF] && msk[FLG_DEN] |=> statusQ[FLG_UNF]
  ) else $error("magnitude below 2^-14 not flagged");

  chk_ovf_threshold: assert property (
    cvtGo && avs_writedata[30:23] >= 8'h8F && avs_writedata[30:23] != EXP_SPECIAL
    |=> statusQ[FLG_OVF]
  ) else $error("magnitude at 2^16 not flagged");

  chk_flags_sticky: assert property (
    !(avs_write && ackQ && avs_address == OFS_STATUS) |=> (statusQ & $past(statusQ)) == $past(statusQ)
  ) else $error("flag dropped without a clear");

  cov_overflow:  cover property (cvtGo && ovfDet);
  cov_underflow: cover property (cvtGo && tiny && inexDet);
  cov_den_fault: cover property (cvtGo && rule5Hit);
  cov_irq:       cover property ($rose(irq));
endmodule

// file: verilog/hpc_pkg.sv
// Purpose: Constants for the single-to-half conversion exception block
// Assumes: Avalon-MM byte addresses, 32-bit data, one aligned word per register
// Notes:   Flag, mask and interrupt-enable words share one bit layout
package hpc_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_CTRL    = 5'h00;  // Masks and rounding_field
  localparam logic [4:0] OFS_STATUS  = 5'h04;  // Sticky flags, write one to clear
  localparam logic [4:0] OFS_IRQ_EN  = 5'h08;  // Interrupt enables
  localparam logic [4:0] OFS_IMM     = 5'h0C;  // Immediate byte for the convert
  localparam logic [4:0] OFS_SRC     = 5'h10;  // Writing a single operand converts it
  localparam logic [4:0] OFS_RESULT  = 5'h14;  // Half result and fault bit
  localparam logic [4:0] OFS_FEATURE = 5'h18;  // Feature query, leaf 01H, third word
  localparam logic [4:0] OFS_XSTATE  = 5'h1C;  // ext_state_enable_reg0

  // ----------------------------------------
  // Flag layout (status, irq enable, mask)
  // ----------------------------------------
  localparam int FLG_INV   = 0;
  localparam int FLG_DEN   = 1;
  localparam int FLG_OVF   = 2;
  localparam int FLG_UNF   = 3;
  localparam int FLG_PREC  = 4;
  localparam int FLG_FAULT = 5;  // Status and irq enable only, no mask bit: an unmasked exception was raised
  localparam int NFLAGS    = 6;
  localparam int NMASKS    = 5;
  localparam int CTRL_RND_LSB   = 5;
  localparam int IMM_RND_SELECT = 2;   // 0: imm[1:0], 1: rounding_field
  localparam int RES_FAULT_BIT  = 16;

  // ----------------------------------------
  // Reset values and fixed words
  // ----------------------------------------
  localparam logic [6:0] CTRL_RST   = 7'h1F;  // All masked, nearest-even
  localparam logic [2:0] XSTATE_RST = 3'h7;   // x87, 128-bit and 256-bit state on
  localparam int FEAT_VEC_BIT  = 28;
  localparam int FEAT_HALF_BIT = 29;
  localparam logic [31:0] FEATURE_WORD = (32'h1 << FEAT_VEC_BIT) | (32'h1 << FEAT_HALF_BIT);

  // ----------------------------------------
  // Number format constants
  // ----------------------------------------
  localparam logic [7:0]  EXP_SPECIAL = 8'hFF;
  localparam int          EXP_REBIAS  = 112;   // 127 - 15
  localparam int          HEXP_OVF    = 31;    // Magnitude at or above 2^16
  localparam int          SHIFT_NORM  = 13;
  localparam int          SHIFT_MAX   = 25;
  localparam logic [15:0] HALF_INF    = 16'h7C00;

  typedef enum logic [1:0] {
    RND_NEAREST = 2'b00,
    RND_DOWN    = 2'b01,
    RND_UP      = 2'b10,
    RND_TRUNC   = 2'b11
  } hpc_rnd_t;
endpackage

// file: dv/hpc_convert_top_tb.sv
// Purpose: Self-checking bench for the single-to-half convert block
// Assumes: Avalon-MM slave with waitrequest, flag layout from hpc_pkg
// Notes:   Expected halves are worked out by hand from the rounding modes
`timescale 1ns/1ns
module hpc_convert_top_tb
  import hpc_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_sys;
  logic        rst;
  logic [4:0]  avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWritedata;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic        irq;
  int          mismatches;
  int          comparisons;
  logic [31:0] xs;
  // Tie pattern: the positive and negative results together differ per mode so each one is seen
  logic [15:0] posExp [4] = '{16'h3C02, 16'h3C01, 16'h3C02, 16'h3C01};
  logic [15:0] negExp [4] = '{16'hBC02, 16'hBC02, 16'hBC01, 16'hBC01};

  hpc_convert_top i_hpc_convert_top (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .avs_address     (avsAddress),
    .avs_read        (avsRead),
    .avs_write       (avsWrite),
    .avs_writedata   (avsWritedata),
    .avs_readdata    (avsReaddata),
    .avs_waitrequest (avsWaitrequest),
    .irq             (irq)
  );

  // ----------------------------------------
  // Clock, 100 MHz
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until the edge that sees waitrequest low; a hang is left to the watchdog
  task automatic bus_access(input logic wr, input logic [4:0] adr, input logic [31:0] wd,
                            output logic [31:0] rdat);
    avsAddress   <= adr;
    avsWrite     <= wr;
    avsRead      <= ~wr;
    avsWritedata <= wd;
    @(posedge clk_sys);
    while (avsWaitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rdat = avsReaddata;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    // Idle edge so the next request never lands in the same time step
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [4:0] adr, input logic [31:0] d);
    logic [31:0] x;
    bus_access(1'b1, adr, d, x);
  endtask

  task automatic rd(input logic [4:0] adr, output logic [31:0] d);
    bus_access(1'b0, adr, 32'h0, d);
  endtask

  task automatic rd_chk(input string what, input logic [4:0] adr, input logic [31:0] exp);
    logic [31:0] x;
    bus_access(1'b0, adr, 32'h0, x);
    check(what, exp, x);
  endtask

  // Convert one operand and compare fault bit plus half result
  task automatic cvt(input logic [31:0] src, input logic [31:0] exp);
    wr(OFS_SRC, src);
    rd_chk("result", OFS_RESULT, exp);
  endtask

  // Compare sticky flags, then clear them all
  task automatic st(input logic [31:0] exp);
    rd_chk("status", OFS_STATUS, exp);
    wr(OFS_STATUS, 32'h0000003F);
  endtask

  // ----------------------------------------
  // Watchdog, far beyond the roughly 150 accesses
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    avsAddress = 5'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // Reset values and read-only words
    rd_chk("ctrl", OFS_CTRL, 32'h0000001F);
    rd_chk("irq_en", OFS_IRQ_EN, 32'h00000000);
    rd_chk("feature", OFS_FEATURE, 32'h30000000);
    rd_chk("xstate", OFS_XSTATE, 32'h00000007);
    // Software gate: both vector state bits must be on before any convert
    rd(OFS_XSTATE, xs);
    check("xstate gate", 32'h00000006, xs & 32'h00000006);
    wr(OFS_FEATURE, 32'h00000000);
    rd_chk("feature ro", OFS_FEATURE, 32'h30000000);
    wr(OFS_RESULT, 32'h0001FFFF);
    rd_chk("result ro", OFS_RESULT, 32'h00000000);
    cvt(32'h3F800000, 32'h00003C00);
    st(32'h00000000);
    // NaNs are never inexact; only the signalling one raises invalid
    cvt(32'hFFC00000, 32'h0000FE00);
    st(32'h00000000);
    cvt(32'h7F800001, 32'h00007E00);
    st(32'h00000001);
    // Every rounding mode, by immediate and by rounding_field
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        wr(OFS_CTRL, 32'h1F | (p == 1 ? (32'(m) << CTRL_RND_LSB) : 32'h0));
        wr(OFS_IMM, p == 1 ? (32'hFC | (32'(~m) & 32'h3)) : (32'hF8 | 32'(m)));
        cvt(32'h3F803000, {16'h0, posExp[m]});
        cvt(32'hBF803000, {16'h0, negExp[m]});
        st(32'h00000010);
      end
    end
    wr(OFS_CTRL, 32'h0000001F);
    wr(OFS_IMM, 32'h00000000);
    cvt(32'h38800000, 32'h00000400);
    st(32'h00000000);
    cvt(32'h33C00000, 32'h00000002);
    st(32'h00000018);
    wr(OFS_CTRL, 32'h00000017);
    cvt(32'h38000000, 32'h00010002);
    st(32'h00000028);
    wr(OFS_CTRL, 32'h0000001F);
    cvt(32'h477FE000, 32'h00007BFF);
    st(32'h00000000);
    cvt(32'h47800000, 32'h00007C00);
    st(32'h00000014);
    cvt(32'hC7800000, 32'h0000FC00);
    st(32'h00000014);
    wr(OFS_CTRL, 32'h0000001B);
    cvt(32'h47800000, 32'h0001FC00);
    st(32'h00000024);
    wr(OFS_CTRL, 32'h0000000F);
    cvt(32'h3F803000, 32'h00013C02);
    st(32'h00000030);
    cvt(32'h47800000, 32'h00017C00);
    st(32'h00000034);
    cvt(32'h00000001, 32'h00017C00);
    st(32'h0000003A);
    // Denormal unmasked: only the denormal flag and fault, result kept
    wr(OFS_CTRL, 32'h0000001D);
    cvt(32'h00000001, 32'h00017C00);
    st(32'h00000022);
    // Sticky flags, interrupt raise, mask and clear
    wr(OFS_CTRL, 32'h0000001F);
    wr(OFS_IRQ_EN, 32'h00000004);
    cvt(32'h47800000, 32'h00007C00);
    cvt(32'h3F800000, 32'h00003C00);
    rd_chk("status sticky", OFS_STATUS, 32'h00000014);
    check("irq set", 32'h1, {31'h0, irq});
    wr(OFS_STATUS, 32'h00000010);
    rd_chk("status w1c", OFS_STATUS, 32'h00000004);
    wr(OFS_IRQ_EN, 32'h00000000);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(OFS_IRQ_EN, 32'h00000004);
    check("irq unmasked", 32'h1, {31'h0, irq});
    wr(OFS_STATUS, 32'h00000004);
    check("irq cleared", 32'h0, {31'h0, irq});
    rd_chk("status clear", OFS_STATUS, 32'h00000000);
    end_sim();
  end
endmodule
